/* sim/lief_tb.sv */
// self-checking bench for lief_top: register bus, event sources, cycle timing
// drives every input itself at the rising edge; no far-side model
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [11:0] src = 12'h000;
    logic [7:0]  phy_byte = 8'h00;
    logic [6:0]  rx_sec = 7'h00;
    logic [12:0] rx_cyc = 13'h0000;
    logic        halt_block;
    logic        ts_on;
    logic        la_en;
    logic [31:0] rq;
    logic        re;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cyc_cnt = 0;

    always #50 ref_clk = ~ref_clk;

    lief_top dut
    (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gp_irq_a(src[0]), .gp_irq_b(src[1]),
        .rx_fifo_pending(src[2]), .phys_resp_busy(src[3]), .tardy_ack_sent(src[4]),
        .phy_reg_valid(src[5]), .phy_reg_data(phy_byte), .subunit_halt(src[6]),
        .phy_status_irq(src[7]), .cycle_start_sent(src[8]), .cycle_start_rx(src[9]),
        .rx_seconds(rx_sec), .rx_cycle(rx_cyc), .subaction_gap_end(src[10]),
        .arb_reset_gap(src[11]), .halt_block(halt_block),
        .isoch_timing_source_on(ts_on), .late_ack_event_enable(la_en)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one idle cycle after each transfer so no signal is assigned twice in a step
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        // the slave answers with no wait states
        chk(n, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // mask narrows each read to the bits under test, cycle flags keep setting
    task evt(input logic [31:0] m, input logic [31:0] e);
        wr(12'h08c, 32'hffffffff);
        wr(12'h088, m);
        apb(1'b0, 12'h080, 32'h0);
        chk(rq, e);
    endtask

    task pulse(input int i, input int len);
        src[i] <= 1'b1;
        cyc(len);
        src[i] <= 1'b0;
        cyc(6);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        evt(32'hffffffff, 32'h0);
        wr(12'h080, 32'hffffffff);
        evt(32'hffffffff, 32'h6ff80000);
        chk({31'h0, halt_block}, 32'h1);
        evt(32'h00080000, 32'h00080000);
        wr(12'h084, 32'h0);
        wr(12'h080, 32'h0);
        evt(32'hffffffff, 32'h6ff80000);
        wr(12'h084, 32'h20000000);
        evt(32'hffffffff, 32'h4ff80000);
        wr(12'h084, 32'hffffffff);
        evt(32'hffffffff, 32'h0);
        chk({31'h0, halt_block}, 32'h0);
        apb(1'b0, 12'h3f0, 32'h0);
        chk({rq[31:1], re}, 32'h1);
    endtask

    task t_gp;
        for (int i = 0; i < 4; i++)
        begin
            wr(12'h0fc, i[0] ? 32'h00800000 : 32'h80000000);
            pulse(i[1] ? 0 : 1, 3);
            evt(32'h40000000, (i[0] == i[1]) ? 32'h40000000 : 32'h0);
            wr(12'h084, 32'hffffffff);
        end
    endtask

    task t_tardy;
        pulse(2, 2);
        evt(32'h08000000, 32'h0);
        wr(12'h050, 32'h20000000);
        chk({31'h0, la_en}, 32'h1);
        for (int k = 2; k < 5; k++)
        begin
            pulse(k, 2);
            evt(32'h08000000, 32'h08000000);
            wr(12'h084, 32'h08000000);
        end
        wr(12'h054, 32'h20000000);
    endtask

    task t_misc;
        phy_byte <= 8'ha5;
        pulse(5, 1);
        evt(32'h04000000, 32'h04000000);
        apb(1'b0, 12'h0ec, 32'h0);
        chk({24'h0, rq[23:16]}, 32'ha5);
        pulse(7, 2);
        evt(32'h00080000, 32'h00080000);
        pulse(6, 2);
        evt(32'h01000000, 32'h01000000);
        chk({31'h0, halt_block}, 32'h1);
        wr(12'h084, 32'hffffffff);
        cyc(2);
        chk({31'h0, halt_block}, 32'h0);
    endtask

    task t_overrun;
        pulse(8, 1);
        cyc(1300);
        evt(32'h02000000, 32'h0);
        wr(12'h0e0, 32'h00200000);
        chk({31'h0, ts_on}, 32'h1);
        pulse(8, 1);
        cyc(600);
        pulse(10, 1);
        cyc(900);
        evt(32'h02000000, 32'h0);
        pulse(8, 1);
        cyc(1300);
        evt(32'h02000000, 32'h02000000);
        chk({31'h0, ts_on}, 32'h0);
    endtask

    task t_cycle;
        wr(12'h0f0, 32'h0a064000);
        rx_sec <= 7'd5;
        rx_cyc <= 13'd100;
        pulse(9, 1);
        evt(32'h00800000, 32'h0);
        rx_cyc <= 13'd101;
        pulse(9, 1);
        evt(32'h00800000, 32'h00800000);
        wr(12'h0f0, 32'h7ff3f4d8);
        wr(12'h084, 32'hffffffff);
        // the timer write restarts the divider, so the wrap comes a full cycle later
        cyc(1250);
        evt(32'h00300000, 32'h00300000);
        wr(12'h084, 32'hffffffff);
        cyc(1280);
        evt(32'h00400000, 32'h00400000);
        wr(12'h084, 32'hffffffff);
        pulse(8, 1);
        cyc(1280);
        evt(32'h00400000, 32'h0);
        wr(12'h084, 32'hffffffff);
        pulse(11, 1);
        evt(32'h00400000, 32'h00400000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 12000)
        begin
            num_errors++;
            report_and_stop;
        end
    end

    initial
    begin
        cyc(4);
        sys_rst <= 1'b0;
        cyc(1);
        t_regs;
        t_gp;
        t_tardy;
        t_misc;
        t_overrun;
        t_cycle;
        report_and_stop;
    end
endmodule
`default_nettype wire

/* sim/lief_top_properties.sv */
// checker for lief_top: bus answer, halt flag, role and enable bits
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module lief_top_properties
(
    input wire logic        ref_clk,                // clock
    input wire logic        sys_rst,                // reset
    input wire logic        psel,                   // apb select
    input wire logic        penable,                // apb access
    input wire logic        pwrite,                 // apb write
    input wire logic [11:0] paddr,                  // apb address
    input wire logic [31:0] pwdata,                 // apb write data
    input wire logic [31:0] prdata,                 // apb read data
    input wire logic        pready,                 // apb ready
    input wire logic        subunit_halt,           // halt source
    input wire logic        cycle_start_sent,       // cycle start out
    input wire logic        subaction_gap_end,      // gap end
    input wire logic        halt_block,             // halt output
    input wire logic        isoch_timing_source_on, // role bit
    input wire logic        late_ack_event_enable   // enable bit
);
    // cycles since a cycle start went out; a gap end stops the count
    logic [15:0] ovr_cnt;
    wire         wr_done = psel && penable && pready && pwrite;
    wire         evt_rd = pready && !pwrite && (paddr == 12'h080 || paddr == 12'h084);
    wire         clr_halt = wr_done && paddr == 12'h084 && pwdata[24];
    wire         src_clr = wr_done && paddr == 12'h0e4 && pwdata[21];
    wire         ack_set = wr_done && paddr == 12'h050 && pwdata[29];

    always @(posedge ref_clk)
    begin
        if (sys_rst)
            ovr_cnt <= 16'h0000;
        else if (cycle_start_sent)
            ovr_cnt <= 16'h0001;
        else if (subaction_gap_end)
            ovr_cnt <= 16'h0000;
        else if (ovr_cnt != 16'h0000 && ovr_cnt != 16'hffff)
            ovr_cnt <= ovr_cnt + 16'h0001;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////////////
    pready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    rsvd_read_zero_a: assert property (evt_rd |-> !prdata[31] && !prdata[28])
        else $error("reserved event bit reads one");
    late_ack_set_a: assert property (ack_set |=> late_ack_event_enable)
        else $error("late ack enable not set");
    halt_rise_a: assert property ($rose(subunit_halt) |-> ##[1:4] halt_block)
        else $error("halt edge did not raise halt_block");
    halt_hold_a: assert property (halt_block && !clr_halt && !$past(clr_halt) |=> halt_block)
        else $error("halt_block dropped without clear");
    halt_clear_a: assert property (clr_halt && !subunit_halt && !$past(subunit_halt)
        |-> ##[1:3] !halt_block)
        else $error("halt_block stuck after clear");
    // margin of fifty cycles either side of the overrun count, edge phases vary
    src_hold_a: assert property (isoch_timing_source_on && !src_clr && ovr_cnt < 16'd1200
        |=> isoch_timing_source_on)
        else $error("role bit dropped early");
    overrun_clr_a: assert property (ovr_cnt == 16'd1300 |-> !isoch_timing_source_on)
        else $error("role bit kept after overrun");

    cover property ($rose(halt_block));
    cover property ($fell(isoch_timing_source_on));
    cover property (evt_rd && prdata != 32'h00000000);
endmodule

bind lief_top lief_top_properties chk_i
(
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .subunit_halt(subunit_halt), .cycle_start_sent(cycle_start_sent),
    .subaction_gap_end(subaction_gap_end), .halt_block(halt_block),
    .isoch_timing_source_on(isoch_timing_source_on),
    .late_ack_event_enable(late_ack_event_enable)
);
`default_nettype wire

/* src/lief_edge_sync.v */
// rising-edge detector bank, one registered pulse per input bit
// SYNC=1 puts two flops in front for inputs from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module lief_edge_sync
#(
    parameter W    = 1,
    parameter SYNC = 0
)
(
    input  wire         ref_clk, // controller clock
    input  wire         sys_rst, // synchronous reset, active high
    input  wire [W-1:0] level,   // source levels
    output wire [W-1:0] rise     // one-cycle pulse per rising edge
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            reg meta;
            reg stable;
            reg prev;
            reg pulse;
            wire seen;
            if (SYNC != 0)
            begin : g_sync
                always @(posedge ref_clk)
                begin
                    if (sys_rst)
                    begin
                        meta   <= 1'b0;
                        stable <= 1'b0;
                    end
                    else
                    begin
                        meta   <= level[i];
                        stable <= meta;
                    end
                end
                assign seen = stable;
            end
            else
            begin : g_direct
                always @(posedge ref_clk)
                begin
                    meta   <= 1'b0;
                    stable <= 1'b0;
                end
                assign seen = level[i];
            end
            always @(posedge ref_clk)
            begin
                if (sys_rst)
                begin
                    prev  <= 1'b0;
                    pulse <= 1'b0;
                end
                else
                begin
                    prev  <= seen;
                    pulse <= seen & ~prev;
                end
            end
            assign rise[i] = pulse;
        end
    endgenerate
endmodule
`default_nettype wire

/* src/lief_map.vh */
// register offsets, event bit positions and timing counts for the link event flags block
// assumes a 10 MHz controller clock and byte addresses on a 32-bit register bus
`ifndef LIEF_MAP_VH
`define LIEF_MAP_VH

`define LIEF_ADDR_W        12
`define LIEF_OFS_HC_SET    12'h050
`define LIEF_OFS_HC_CLR    12'h054
`define LIEF_OFS_EVT_SET   12'h080
`define LIEF_OFS_EVT_CLR   12'h084
`define LIEF_OFS_MSK_SET   12'h088
`define LIEF_OFS_MSK_CLR   12'h08c
`define LIEF_OFS_LC_SET    12'h0e0
`define LIEF_OFS_LC_CLR    12'h0e4
`define LIEF_OFS_PHYC      12'h0ec
`define LIEF_OFS_CYT       12'h0f0
`define LIEF_OFS_GPIO      12'h0fc

`define LIEF_B_VENDOR      30
`define LIEF_B_SOFT        29
`define LIEF_B_TARDY       27
`define LIEF_B_PHYREG      26
`define LIEF_B_OVERRUN     25
`define LIEF_B_FATAL       24
`define LIEF_B_MISMATCH    23
`define LIEF_B_LOST        22
`define LIEF_B_SEC64       21
`define LIEF_B_NEWCYC      20
`define LIEF_B_PHYSTAT     19
`define LIEF_EVT_IMPL      32'h6ff80000

`define LIEF_B_LATE_ACK_EN 29
`define LIEF_B_TIMING_SRC  21
`define LIEF_B_GP_B_EN     31
`define LIEF_B_GP_A_EN     23
`define LIEF_PHY_BYTE_HI   23
`define LIEF_PHY_BYTE_LO   16
`define LIEF_SEC_HI        31
`define LIEF_SEC_LO        25
`define LIEF_CNT_HI        24
`define LIEF_CNT_LO        12

`define LIEF_CLK_NS        100
`define LIEF_CYCLE_NS      125000
// 125 us in 100 ns clocks, sized to the 11-bit divider so nothing is cut silently
`define LIEF_CYCLE_TICKS   11'd1250
`define LIEF_CNT_MAX       13'h1f3f

`endif

/* src/lief_top.v */
// link interrupt event flags, bits 31..19, with mask and the few control registers they use
// assumes an APB master on ref_clk; gp irq pins are asynchronous, all else is on ref_clk
//
// Overview of operation
// - Bits 31 and 28 read zero and never latch anything.
// - Bit 30 latches when either general-purpose pin interrupt asserts.
// - Each pin counts only while its enable bit (31 or 23) is one.
// - Bit 29 is set only by software, for its own interrupts.
// - Bit 27 latches only while the late-ack enable bit is one.
// - Bit 27 sources: receive data waiting, response unit busy, tardy ack sent.
// - Bit 26 sets when a PHY register byte arrives; byte readable at ECh.
// - With timing source on, bit 25 sets if a cycle exceeds 125 us.
// - A cycle overrun clears the timing-source role bit.
// - Bit 24 sets on any error that halts a subunit.
// - While bit 24 is set, halted contexts may not set normal interrupts.
// - Bit 23 sets when received cycle start disagrees with the cycle timer.
// - Bit 22 sets when no cycle start occurs between two new cycles.
// - Bit 22 may also set early, on arbitration reset gap without cycle start.
// - Bit 21 sets whenever seconds counter bit six changes.
// - Bit 20 sets whenever the cycle count low bit toggles.
// - Bit 19 sets when the PHY requests an interrupt by status transfer.
// - Flags set by source edge or set-port write; cleared only by clear port.
// - Reading the event register returns flags ANDed with mask.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "lief_map.vh"
module lief_top
(
    input  wire        ref_clk,            // controller clock, 10 MHz
    input  wire        sys_rst,            // synchronous reset, active high
    input  wire        psel,               // apb select
    input  wire        penable,            // apb access phase
    input  wire        pwrite,             // apb direction, high for write
    input  wire [11:0] paddr,              // apb byte address
    input  wire [31:0] pwdata,             // apb write data
    output reg  [31:0] prdata,             // apb read data
    output reg         pready,             // apb ready
    output reg         pslverr,            // apb error on unmapped address
    input  wire        gp_irq_a,           // general-purpose interrupt pin a, async
    input  wire        gp_irq_b,           // general-purpose interrupt pin b, async
    input  wire        rx_fifo_pending,    // receive data waiting for the host
    input  wire        phys_resp_busy,     // physical response unit busy
    input  wire        tardy_ack_sent,     // a tardy acknowledge went out
    input  wire        phy_reg_valid,      // phy register byte arrived
    input  wire [7:0]  phy_reg_data,       // the phy register byte
    input  wire        subunit_halt,       // some subunit stopped on an error
    input  wire        phy_status_irq,     // phy interrupt request by status transfer
    input  wire        cycle_start_sent,   // pulse: cycle start transmission begins
    input  wire        cycle_start_rx,     // pulse: cycle start received
    input  wire [6:0]  rx_seconds,         // seconds carried by the received cycle start
    input  wire [12:0] rx_cycle,           // cycle number carried by the received cycle start
    input  wire        subaction_gap_end,  // pulse: end of a subaction gap
    input  wire        arb_reset_gap,      // pulse: arbitration reset gap seen
    output reg         halt_block,         // blocks normal interrupts of halted contexts
    output reg         isoch_timing_source_on, // timing-source role bit
    output reg         late_ack_event_enable   // late-ack enable bit
);
    localparam [10:0] CYC_TICKS = `LIEF_CYCLE_TICKS;

    reg  [31:0] event_flag_set_clear;
    reg  [31:0] evt_mask;
    reg         gp_irq_a_enable;
    reg         gp_irq_b_enable;
    reg  [7:0]  phy_byte;
    reg  [6:0]  seconds_count_field;
    reg  [12:0] cycle_number_field;
    reg  [10:0] cyc_div;
    reg  [10:0] ovr_cnt;
    reg         ovr_run;
    reg         ovr_hit;
    reg         mismatch_hit;
    reg         lost_hit;
    reg         cs_seen;
    reg         sec6_prev;
    reg         cnt0_prev;
    reg  [31:0] next_event;
    reg  [31:0] rd_mux;
    reg         rd_hit;
    reg  [31:0] hw_set;

    wire [1:0]  gp_rise;
    wire [3:0]  lvl_rise;
    wire        wr_go = psel & penable & pready & pwrite;
    wire        cyc_wrap = (cyc_div == CYC_TICKS - 11'h001);

    ////////////////////////////////////////////////////////////////////////////////
    // source edges; pins go through two flops, link-side levels do not

    lief_edge_sync #(.W(2), .SYNC(1)) u_gp_edge
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .level   ({gp_irq_b, gp_irq_a}),
        .rise    (gp_rise)
    );

    lief_edge_sync #(.W(4), .SYNC(0)) u_lvl_edge
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .level   ({phy_status_irq, subunit_halt, phy_reg_valid,
                   late_ack_event_enable & (rx_fifo_pending | phys_resp_busy | tardy_ack_sent)}),
        .rise    (lvl_rise)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // cycle timer: advances one cycle per 125 us in either role; while not timing source, received starts also reload it

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cyc_div             <= 11'h000;
            cycle_number_field  <= 13'h0000;
            seconds_count_field <= 7'h00;
        end
        else if (wr_go && paddr == `LIEF_OFS_CYT)
        begin
            cyc_div             <= 11'h000;
            cycle_number_field  <= pwdata[`LIEF_CNT_HI:`LIEF_CNT_LO];
            seconds_count_field <= pwdata[`LIEF_SEC_HI:`LIEF_SEC_LO];
        end
        else if (cycle_start_rx && !isoch_timing_source_on)
        begin
            cyc_div             <= 11'h000;
            cycle_number_field  <= rx_cycle;
            seconds_count_field <= rx_seconds;
        end
        else if (cyc_wrap)
        begin
            cyc_div <= 11'h000;
            if (cycle_number_field == `LIEF_CNT_MAX)
            begin
                cycle_number_field  <= 13'h0000;
                seconds_count_field <= seconds_count_field + 7'h01;
            end
            else
            begin
                cycle_number_field <= cycle_number_field + 13'h0001;
            end
        end
        else
        begin
            cyc_div <= cyc_div + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // cycle supervision: overrun, mismatch and lost-cycle detection

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ovr_cnt      <= 11'h000;
            ovr_run      <= 1'b0;
            ovr_hit      <= 1'b0;
            mismatch_hit <= 1'b0;
            lost_hit     <= 1'b0;
            cs_seen      <= 1'b0;
            sec6_prev    <= 1'b0;
            cnt0_prev    <= 1'b0;
        end
        else
        begin
            sec6_prev <= seconds_count_field[6];
            cnt0_prev <= cycle_number_field[0];
            ovr_hit   <= 1'b0;
            if (cycle_start_sent)
            begin
                ovr_run <= 1'b1;
                ovr_cnt <= 11'h000;
            end
            else if (subaction_gap_end)
            begin
                ovr_run <= 1'b0;
            end
            else if (ovr_run)
            begin
                // count saturates; one pulse, only with timing source on, when the 125 us limit is first passed
                if (ovr_cnt == CYC_TICKS)
                begin
                    ovr_run <= 1'b0;
                    ovr_hit <= isoch_timing_source_on;
                end
                else
                begin
                    ovr_cnt <= ovr_cnt + 11'h001;
                end
            end
            mismatch_hit <= cycle_start_rx &&
                            (rx_seconds != seconds_count_field ||
                             rx_cycle != cycle_number_field);
            lost_hit <= 1'b0;
            if (cycle_number_field[0] != cnt0_prev)
            begin
                lost_hit <= ~cs_seen;
                cs_seen  <= 1'b0;
            end
            else if (cycle_start_sent || cycle_start_rx)
            begin
                cs_seen <= 1'b1;
            end
            else if (arb_reset_gap && !cs_seen)
            begin
                lost_hit <= 1'b1;
                cs_seen  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event flags: hardware set wins over a clear in the same cycle

    always @*
    begin
        hw_set = 32'h00000000;
        hw_set[`LIEF_B_VENDOR]   = (gp_rise[0] & gp_irq_a_enable) |
                                   (gp_rise[1] & gp_irq_b_enable);
        hw_set[`LIEF_B_TARDY]    = lvl_rise[0];
        hw_set[`LIEF_B_PHYREG]   = lvl_rise[1];
        hw_set[`LIEF_B_FATAL]    = lvl_rise[2];
        hw_set[`LIEF_B_PHYSTAT]  = lvl_rise[3];
        hw_set[`LIEF_B_OVERRUN]  = ovr_hit;
        hw_set[`LIEF_B_MISMATCH] = mismatch_hit;
        hw_set[`LIEF_B_LOST]     = lost_hit;
        hw_set[`LIEF_B_SEC64]    = seconds_count_field[6] ^ sec6_prev;
        hw_set[`LIEF_B_NEWCYC]   = cycle_number_field[0] ^ cnt0_prev;
        next_event = event_flag_set_clear;
        if (wr_go && paddr == `LIEF_OFS_EVT_CLR)
        begin
            next_event = next_event & ~pwdata;
        end
        if (wr_go && paddr == `LIEF_OFS_EVT_SET)
        begin
            next_event = next_event | pwdata;
        end
        next_event = (next_event | hw_set) & `LIEF_EVT_IMPL;
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            event_flag_set_clear <= 32'h00000000;
            halt_block           <= 1'b0;
        end
        else
        begin
            event_flag_set_clear <= next_event;
            halt_block           <= next_event[`LIEF_B_FATAL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            evt_mask               <= 32'h00000000;
            gp_irq_a_enable        <= 1'b0;
            gp_irq_b_enable        <= 1'b0;
            late_ack_event_enable  <= 1'b0;
            isoch_timing_source_on <= 1'b0;
            phy_byte               <= 8'h00;
        end
        else
        begin
            if (phy_reg_valid)
            begin
                phy_byte <= phy_reg_data;
            end
            if (wr_go && paddr == `LIEF_OFS_MSK_SET)
            begin
                evt_mask <= (evt_mask | pwdata) & `LIEF_EVT_IMPL;
            end
            if (wr_go && paddr == `LIEF_OFS_MSK_CLR)
            begin
                evt_mask <= evt_mask & ~pwdata;
            end
            if (wr_go && paddr == `LIEF_OFS_GPIO)
            begin
                gp_irq_a_enable <= pwdata[`LIEF_B_GP_A_EN];
                gp_irq_b_enable <= pwdata[`LIEF_B_GP_B_EN];
            end
            if (wr_go && paddr == `LIEF_OFS_HC_SET && pwdata[`LIEF_B_LATE_ACK_EN])
            begin
                late_ack_event_enable <= 1'b1;
            end
            if (wr_go && paddr == `LIEF_OFS_HC_CLR && pwdata[`LIEF_B_LATE_ACK_EN])
            begin
                late_ack_event_enable <= 1'b0;
            end
            if (wr_go && paddr == `LIEF_OFS_LC_SET && pwdata[`LIEF_B_TIMING_SRC])
            begin
                isoch_timing_source_on <= 1'b1;
            end
            if (wr_go && paddr == `LIEF_OFS_LC_CLR && pwdata[`LIEF_B_TIMING_SRC])
            begin
                isoch_timing_source_on <= 1'b0;
            end
            // the overrun clears the role even against a software set in the same cycle
            if (ovr_hit)
            begin
                isoch_timing_source_on <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, read data captured in the setup cycle

    always @*
    begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (paddr)
            `LIEF_OFS_EVT_SET, `LIEF_OFS_EVT_CLR:
                rd_mux = event_flag_set_clear & evt_mask;
            `LIEF_OFS_MSK_SET, `LIEF_OFS_MSK_CLR:
                rd_mux = evt_mask;
            `LIEF_OFS_HC_SET, `LIEF_OFS_HC_CLR:
                rd_mux[`LIEF_B_LATE_ACK_EN] = late_ack_event_enable;
            `LIEF_OFS_LC_SET, `LIEF_OFS_LC_CLR:
                rd_mux[`LIEF_B_TIMING_SRC] = isoch_timing_source_on;
            `LIEF_OFS_PHYC:
                rd_mux[`LIEF_PHY_BYTE_HI:`LIEF_PHY_BYTE_LO] = phy_byte;
            `LIEF_OFS_CYT:
                rd_mux = {seconds_count_field, cycle_number_field, 1'b0, cyc_div};
            `LIEF_OFS_GPIO:
            begin
                rd_mux[`LIEF_B_GP_A_EN] = gp_irq_a_enable;
                rd_mux[`LIEF_B_GP_B_EN] = gp_irq_b_enable;
            end
            default:
                rd_hit = 1'b0;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~rd_hit;
            if (psel && !penable && !pwrite)
            begin
                prdata <= rd_mux;
            end
        end
    end
endmodule
`default_nettype wire
